// ### verilog/ddr_burst_pkg.sv
// Purpose: Shared constants for the four-word burst DDR SRAM interface
// Assumes: One 36-bit word per array entry, four 9-bit byte lanes
// Notes:   Imported whole by every design module of the block
package ddr_burst_pkg;

  localparam int WORD_W   = 36;
  localparam int LANE_W   = 9;
  localparam int LANES    = 4;
  localparam int ADDR_W   = 21;
  localparam int CNT_W    = 2;
  localparam int SYNC_W   = 2;

  // Word offsets inside a burst, relative to the loaded start address
  localparam logic [CNT_W-1:0] BEAT0 = 2'h0;
  localparam logic [CNT_W-1:0] BEAT1 = 2'h1;
  localparam logic [CNT_W-1:0] BEAT2 = 2'h2;
  localparam logic [CNT_W-1:0] BEAT3 = 2'h3;

  // Bit positions inside the synchronised strap vector
  localparam int STRAP_BYPASS = 0;
  localparam int STRAP_SINGLE = 1;

  // Bit positions inside the burst-done toggle vector
  localparam int DONE_WR = 0;
  localparam int DONE_RD = 1;

endpackage : ddr_burst_pkg

// ### verilog/ddr_level_sync.sv
// Purpose: Two-flop synchroniser for a vector of independent levels
// Assumes: Each bit changes slowly compared with the receiving clock
// Notes:   The first stage feeds only the second stage
`timescale 1ns/1ps
module ddr_level_sync
  import ddr_burst_pkg::*;
#(
  parameter int W = SYNC_W
)
(
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Levels in and out
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_q <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule : ddr_level_sync

// ### verilog/ddr_burst_sram.sv
// Purpose: Device side of a four-word burst DDR SRAM with echo clocks
// Assumes: Input and output clock pairs share one frequency; i_core_clk unrelated
// Notes:   Array read is combinational; output registers launch on C/C# edges, or on K/K# when i_single_clk is high
//
// What this block does
// [RQ1] Take addresses only on alternate true-clock edges
// [RQ2] Write words taken on true and complement edges
// [RQ3] Launch read data on output clock pair
// [RQ4] Two-bit counter from address low bits, four words
// [RQ5] Bypass pin high gives 1.5 cycle latency
// [RQ6] Bypass pin low gives one cycle latency
// [RQ7] Every synchronous input registered before use
// [RQ8] Read data leaves through output-clock registers
// [RQ9] Array writes finish without controller timing
// [RQ10] Only rising edges of every clock used
// [RQ11] Two mega-words of 36 bits, shared data pins
// [RQ12] Read data aligned to two echo clocks
// [RQ13] Active-low load starts four-word transaction
// [RQ14] Active-low lane masks keep 9-bit lanes unaltered
// [RQ15] Data drivers released when no read runs
// [RQ16] Controller leaves one idle edge between commands
`timescale 1ns/1ps
module ddr_burst_sram
  import ddr_burst_pkg::*;
#(
  parameter int AW = ADDR_W
)
(
  // Core clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  // Input clock pair
  input  wire logic              i_kclk,
  input  wire logic              i_kclk_n,
  // Output clock pair and its strap
  input  wire logic              i_oclk,
  input  wire logic              i_oclk_n,
  input  wire logic              i_single_clk,
  // Command and PLL bypass strap
  input  wire logic              i_load_n,
  input  wire logic              i_read_not_write,
  input  wire logic [AW-1:0]     i_addr,
  input  wire logic              i_pll_bypass_n,
  // Data pins
  input  wire logic [WORD_W-1:0] i_dq,
  input  wire logic [LANES-1:0]  i_byte_lane_mask_n,
  output logic      [WORD_W-1:0] o_dq,
  output logic                   o_dq_oe,
  // Echo clocks
  output logic                   o_returned_strobe_pos,
  output logic                   o_returned_strobe_neg,
  // Core-side burst events
  output logic                   o_write_burst_done,
  output logic                   o_read_burst_done
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  localparam int DEPTH = 1 << AW;

  logic [WORD_W-1:0] mem [DEPTH];                       // see [RQ11]

  function automatic logic [AW-1:0] beat_addr(input logic [AW-1:0]    base,
                                              input logic [CNT_W-1:0] beat);
    logic [CNT_W-1:0] cnt;
    cnt       = base[CNT_W-1:0] + beat;                 // see [RQ4]
    beat_addr = {base[AW-1:CNT_W], cnt};
  endfunction : beat_addr

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser for the input-clock domain

  logic rst_k_meta_q;
  logic rst_k_q;

  always_ff @(posedge i_kclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rst_k_meta_q <= 1'b1;
      rst_k_q      <= 1'b1;
    end
    else
    begin
      rst_k_meta_q <= 1'b0;
      rst_k_q      <= rst_k_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Straps into the input-clock domain

  logic [SYNC_W-1:0] strap_q;
  logic              lat15;
  logic              single_clk;

  ddr_level_sync #(.W(SYNC_W)) u_strap_sync
  (
    .i_clk   (i_kclk),
    .i_rst   (rst_k_q),
    .i_async ({i_single_clk, i_pll_bypass_n}),
    .o_sync  (strap_q)
  );

  assign lat15      = strap_q[STRAP_BYPASS];
  assign single_clk = strap_q[STRAP_SINGLE];

  ////////////////////////////////////////////////////////////////////////////
  // Input registers on the true and complement input clocks

  logic              load_n_q;
  logic              rnw_q;
  logic [AW-1:0]     addr_q;
  logic [WORD_W-1:0] dk_q;
  logic [LANES-1:0]  mk_n_q;
  logic [WORD_W-1:0] dkn_q;
  logic [LANES-1:0]  mkn_n_q;

  always_ff @(posedge i_kclk or posedge rst_k_q)
  begin
    if (rst_k_q)
    begin
      load_n_q <= 1'b1;
      rnw_q    <= 1'b1;
      addr_q   <= '0;
      dk_q     <= '0;
      mk_n_q   <= '1;
    end
    else
    begin
      load_n_q <= i_load_n;                             // see [RQ7]
      rnw_q    <= i_read_not_write;                     // see [RQ7]
      addr_q   <= i_addr;                               // see [RQ7]
      dk_q     <= i_dq;                                 // see [RQ2]
      mk_n_q   <= i_byte_lane_mask_n;                   // see [RQ14]
    end
  end

  // Mid-cycle words on the complement clock rising edge
  always_ff @(posedge i_kclk_n or posedge rst_k_q)     // see [RQ10]
  begin
    if (rst_k_q)
    begin
      dkn_q   <= '0;
      mkn_n_q <= '1;
    end
    else
    begin
      dkn_q   <= i_dq;                                  // see [RQ2]
      mkn_n_q <= i_byte_lane_mask_n;                    // see [RQ14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command acceptance

  logic cmd_ok;
  logic cmd_rd;
  logic cmd_wr;
  logic hold_q;

  assign cmd_ok = !load_n_q && !hold_q;                 // see [RQ13]
  assign cmd_rd = cmd_ok && rnw_q;
  assign cmd_wr = cmd_ok && !rnw_q;

  // Edge after an accepted command never takes an address
  always_ff @(posedge i_kclk or posedge rst_k_q)
  begin
    if (rst_k_q)
      hold_q <= 1'b0;
    else
      hold_q <= cmd_ok;                                 // see [RQ1] see [RQ16]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst sequencing

  logic          rs1_q;
  logic          rs2_q;
  logic          ws1_q;
  logic          ws2_q;
  logic [AW-1:0] a1_q;
  logic [AW-1:0] a2_q;
  logic [SYNC_W-1:0] done_tgl_q;

  always_ff @(posedge i_kclk or posedge rst_k_q)
  begin
    if (rst_k_q)
    begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
      ws1_q <= 1'b0;
      ws2_q <= 1'b0;
    end
    else
    begin
      rs1_q <= cmd_rd;                                  // see [RQ4]
      rs2_q <= rs1_q;
      ws1_q <= cmd_wr;
      ws2_q <= ws1_q;
    end
  end

  always_ff @(posedge i_kclk or posedge rst_k_q)
  begin
    if (rst_k_q)
    begin
      a1_q <= '0;
      a2_q <= '0;
    end
    else
    begin
      a1_q <= addr_q;
      a2_q <= a1_q;
    end
  end

  always_ff @(posedge i_kclk or posedge rst_k_q)
  begin
    if (rst_k_q)
      done_tgl_q <= '0;
    else
    begin
      if (ws2_q)
        done_tgl_q[DONE_WR] <= ~done_tgl_q[DONE_WR];
      if (rs2_q)
        done_tgl_q[DONE_RD] <= ~done_tgl_q[DONE_RD];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed array write, two words per input clock period

  logic [AW-1:0]     wa_even;
  logic [AW-1:0]     wa_odd;
  logic [WORD_W-1:0] old_even;
  logic [WORD_W-1:0] old_odd;
  logic [WORD_W-1:0] new_even;
  logic [WORD_W-1:0] new_odd;

  assign wa_even  = ws1_q ? beat_addr(a1_q, BEAT0) : beat_addr(a2_q, BEAT2);
  assign wa_odd   = ws1_q ? beat_addr(a1_q, BEAT1) : beat_addr(a2_q, BEAT3);
  assign old_even = mem[wa_even];
  assign old_odd  = mem[wa_odd];

  // Masked lanes keep their stored bits
  for (genvar l = 0; l < LANES; l++)
  begin : g_lane
    assign new_even[l*LANE_W +: LANE_W] = mk_n_q[l]  ? old_even[l*LANE_W +: LANE_W]
                                                     : dk_q[l*LANE_W +: LANE_W];  // see [RQ14]
    assign new_odd[l*LANE_W +: LANE_W]  = mkn_n_q[l] ? old_odd[l*LANE_W +: LANE_W]
                                                     : dkn_q[l*LANE_W +: LANE_W]; // see [RQ14]
  end

  always_ff @(posedge i_kclk)
  begin
    if (!rst_k_q && (ws1_q || ws2_q))                   // see [RQ9]
    begin
      mem[wa_even] <= new_even;                         // see [RQ4]
      mem[wa_odd]  <= new_odd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output clock selection and echo clocks

  logic out_clk;
  logic out_clk_n;

  assign out_clk   = single_clk ? i_kclk   : i_oclk;    // see [RQ3] see [RQ8]
  assign out_clk_n = single_clk ? i_kclk_n : i_oclk_n;  // see [RQ3] see [RQ8]

  assign o_returned_strobe_pos = out_clk;               // see [RQ12]
  assign o_returned_strobe_neg = out_clk_n;             // see [RQ12]

  ////////////////////////////////////////////////////////////////////////////
  // Read word selection per output edge

  logic [AW-1:0] pos_addr;
  logic          pos_val;
  logic [AW-1:0] neg_addr;
  logic          neg_val;

  always_comb
  begin
    pos_addr = beat_addr(addr_q, BEAT0);
    pos_val  = 1'b0;
    neg_addr = beat_addr(a1_q, BEAT0);
    neg_val  = 1'b0;
    if (lat15)
    begin
      // Half a cycle later: word 0 on the complement edge
      if (rs1_q)
      begin
        pos_addr = beat_addr(a1_q, BEAT1);              // see [RQ5]
        pos_val  = 1'b1;
        neg_addr = beat_addr(a1_q, BEAT0);
        neg_val  = 1'b1;
      end
      else if (rs2_q)
      begin
        pos_addr = beat_addr(a2_q, BEAT3);              // see [RQ5]
        pos_val  = 1'b1;
        neg_addr = beat_addr(a2_q, BEAT2);
        neg_val  = 1'b1;
      end
    end
    else
    begin
      if (cmd_rd)
      begin
        pos_addr = beat_addr(addr_q, BEAT0);            // see [RQ6]
        pos_val  = 1'b1;
      end
      else if (rs1_q)
      begin
        pos_addr = beat_addr(a1_q, BEAT2);              // see [RQ6]
        pos_val  = 1'b1;
      end
      if (rs1_q)
      begin
        neg_addr = beat_addr(a1_q, BEAT1);
        neg_val  = 1'b1;
      end
      else if (rs2_q)
      begin
        neg_addr = beat_addr(a2_q, BEAT3);
        neg_val  = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers on the output clock pair

  logic [WORD_W-1:0] qpos_q;
  logic              vpos_q;
  logic [WORD_W-1:0] qneg_q;
  logic              vneg_q;

  always_ff @(posedge out_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      qpos_q <= '0;
      vpos_q <= 1'b0;
    end
    else
    begin
      qpos_q <= mem[pos_addr];                          // see [RQ8]
      vpos_q <= pos_val;
    end
  end

  always_ff @(posedge out_clk_n or posedge i_rst)      // see [RQ10]
  begin
    if (i_rst)
    begin
      qneg_q <= '0;
      vneg_q <= 1'b0;
    end
    else
    begin
      qneg_q <= mem[neg_addr];                          // see [RQ8]
      vneg_q <= neg_val;
    end
  end

  // Pin shows the register of the most recent output edge
  assign o_dq    = out_clk ? qpos_q : qneg_q;           // see [RQ12]
  assign o_dq_oe = out_clk ? vpos_q : vneg_q;           // see [RQ15]

  ////////////////////////////////////////////////////////////////////////////
  // Burst events into the core clock domain

  logic [SYNC_W-1:0] done_sync;
  logic [SYNC_W-1:0] done_last_q;

  ddr_level_sync #(.W(SYNC_W)) u_done_sync
  (
    .i_clk   (i_core_clk),
    .i_rst   (i_rst),
    .i_async (done_tgl_q),
    .o_sync  (done_sync)
  );

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      done_last_q        <= '0;
      o_write_burst_done <= 1'b0;
      o_read_burst_done  <= 1'b0;
    end
    else
    begin
      done_last_q        <= done_sync;
      o_write_burst_done <= done_sync[DONE_WR] ^ done_last_q[DONE_WR];
      o_read_burst_done  <= done_sync[DONE_RD] ^ done_last_q[DONE_RD];
    end
  end

endmodule : ddr_burst_sram

// ### verif/ddr_burst_monitor.sv
// Purpose: Port checker for the burst DDR SRAM
// Assumes: K# is the inverse of K; core clock unrelated to K
// Notes:   Bound to every ddr_burst_sram instance
`timescale 1ns/1ps
module ddr_burst_monitor
  import ddr_burst_pkg::*;
(
  // Clocks, reset and strap
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_kclk,
  input wire logic i_oclk,
  input wire logic i_single_clk,
  // Command
  input wire logic i_load_n,
  input wire logic i_read_not_write,
  // Outputs watched
  input wire logic o_dq_oe,
  input wire logic o_returned_strobe_pos,
  input wire logic o_returned_strobe_neg,
  input wire logic o_write_burst_done,
  input wire logic o_read_burst_done
);
  ////////////////////////////////////////
  // Command acceptance tracker
  logic acc_q;
  always_ff @(posedge i_kclk or posedge i_rst)
  begin
    if (i_rst)
      acc_q <= 1'b0;
    else
      acc_q <= !i_load_n && !acc_q;
  end
  sequence rd_cmd;
    !i_load_n && !acc_q && i_read_not_write;
  endsequence
  sequence wr_cmd;
    !i_load_n && !acc_q && !i_read_not_write;
  endsequence
  ////////////////////////////////////////
  AST_RD_OE: assert property (@(posedge i_kclk) disable iff (i_rst) rd_cmd |-> ##2 o_dq_oe [*2])
    else $error("read burst not driven for two cycles");
  AST_WR_QUIET: assert property (@(posedge i_kclk) disable iff (i_rst)
    wr_cmd |-> ##2 !o_dq_oe ##1 !o_dq_oe)
    else $error("data driven during write burst");
  AST_OE_CAUSE: assert property (@(posedge i_kclk) disable iff (i_rst)
    $rose(o_dq_oe) |-> !$past(i_load_n, 2) && $past(i_read_not_write, 2))
    else $error("data drivers enabled without read");
  AST_ECHO_PAIR: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_returned_strobe_neg != o_returned_strobe_pos)
    else $error("echo strobes not complementary");
  AST_ECHO_C: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (!i_single_clk) [*8] |-> o_returned_strobe_pos == i_oclk)
    else $error("echo does not follow output clock");
  AST_ECHO_K: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_single_clk [*8] |-> o_returned_strobe_pos == i_kclk)
    else $error("echo does not follow input clock");
  AST_WDONE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_write_burst_done |=> !o_write_burst_done)
    else $error("write done wider than one cycle");
  AST_RDONE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_read_burst_done |=> !o_read_burst_done)
    else $error("read done wider than one cycle");
endmodule : ddr_burst_monitor

bind ddr_burst_sram ddr_burst_monitor mon (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_kclk(i_kclk), .i_oclk(i_oclk),
  .i_single_clk(i_single_clk), .i_load_n(i_load_n), .i_read_not_write(i_read_not_write), .o_dq_oe(o_dq_oe),
  .o_returned_strobe_pos(o_returned_strobe_pos), .o_returned_strobe_neg(o_returned_strobe_neg),
  .o_write_burst_done(o_write_burst_done), .o_read_burst_done(o_read_burst_done));

// ### verif/ddr_ctrl_model.sv
// Purpose: Memory controller model on the K clock pair
// Assumes: K# is the inverse of K
// Notes:   Released address and data lines show the inverse of their last value
`timescale 1ns/1ps
module ddr_ctrl_model
  import ddr_burst_pkg::*;
#(
  parameter int AW = ADDR_W
)
(
  // Clocks and strap
  input  wire logic              i_kclk,
  input  wire logic              i_kclk_n,
  input  wire logic              i_pll_bypass_n,
  // Read return
  input  wire logic [WORD_W-1:0] i_dq,
  input  wire logic              i_dq_oe,
  input  wire logic              i_strobe_pos,
  input  wire logic              i_strobe_neg,
  // Command and write data
  output logic                   o_load_n = 1'b1,
  output logic                   o_read_not_write = 1'b1,
  output logic      [AW-1:0]     o_addr = '0,
  output logic      [WORD_W-1:0] o_dq = '0,
  output logic      [LANES-1:0]  o_mask_n = '1
);
  task automatic issue(input logic [AW-1:0] a, input logic rnw);
    @(posedge i_kclk);
    o_load_n <= 1'b0;
    o_read_not_write <= rnw;
    o_addr <= a;
    @(posedge i_kclk);
    o_addr <= ~a;
  endtask : issue

  task automatic write_burst(input logic [AW-1:0] a, input logic [4*WORD_W-1:0] d,
                             input logic [4*LANES-1:0] m, input logic extra);
    issue(a, 1'b0);
    o_load_n <= !extra;
    o_read_not_write <= 1'b1;
    o_dq <= d[WORD_W-1:0];
    o_mask_n <= m[LANES-1:0];
    for (int i = 1; i < 4; i++)
    begin
      if (i == 2)
        @(posedge i_kclk_n);
      else
        @(posedge i_kclk);
      o_load_n <= 1'b1;
      o_dq <= d[WORD_W*i +: WORD_W];
      o_mask_n <= m[LANES*i +: LANES];
    end
    @(posedge i_kclk_n);
    o_dq <= ~o_dq;
  endtask : write_burst

  task automatic read_burst(input logic [AW-1:0] a, output logic [4*WORD_W-1:0] q);
    issue(a, 1'b1);
    o_load_n <= 1'b1;
    #2;
    // First true-phase output edge after the command, then half a cycle more when i_pll_bypass_n is high
    @(posedge i_strobe_pos);
    if (i_pll_bypass_n)
      @(posedge i_strobe_neg);
    for (int i = 0; i < 4; i++)
    begin
      #12;
      q[WORD_W*i +: WORD_W] = i_dq_oe ? i_dq : 'x;
      if (i_strobe_pos)
        @(posedge i_strobe_neg);
      else
        @(posedge i_strobe_pos);
    end
  endtask : read_burst
endmodule : ddr_ctrl_model

// ### verif/ddr_burst_sram_test.sv
// Purpose: Self-checking bench for the burst DDR SRAM
// Assumes: Output clock pair aligned with K, halted in single-clock mode
// Notes:   Array shrunk to AW address bits
`timescale 1ns/1ps
module ddr_burst_sram_test;
  import ddr_burst_pkg::*;
  localparam int AW = 8;
  localparam int BW = 4 * WORD_W;
  logic               i_core_clk = 1'b0;
  logic               i_rst = 1'b1;
  logic               kclk = 1'b0;
  logic               single = 1'b0;
  logic               bypass_n = 1'b1;
  logic               load_n, rnw, dq_oe, s_pos, s_neg, wr_done, rd_done;
  logic [AW-1:0]      addr, a;
  logic [WORD_W-1:0]  dq_in, dq_out;
  logic [LANES-1:0]   mask_n;
  logic [WORD_W-1:0]  mem [2**AW];
  logic [BW-1:0]      q, d;
  logic [4*LANES-1:0] m;
  int                 errors = 0;
  int                 checks = 0;
  int                 n_wr = 0;
  int                 wr_seen = 0;
  int                 rd_seen = 0;

  always #12.5 i_core_clk = ~i_core_clk;
  always #24 kclk = ~kclk;

  ddr_burst_sram #(.AW(AW)) dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_kclk(kclk), .i_kclk_n(~kclk),
    .i_oclk(kclk & ~single), .i_oclk_n(~(kclk & ~single)), .i_single_clk(single), .i_load_n(load_n),
    .i_read_not_write(rnw), .i_addr(addr), .i_pll_bypass_n(bypass_n), .i_dq(dq_in), .i_byte_lane_mask_n(mask_n),
    .o_dq(dq_out), .o_dq_oe(dq_oe), .o_returned_strobe_pos(s_pos), .o_returned_strobe_neg(s_neg),
    .o_write_burst_done(wr_done), .o_read_burst_done(rd_done));
  ddr_ctrl_model #(.AW(AW)) ctrl (.i_kclk(kclk), .i_kclk_n(~kclk), .i_pll_bypass_n(bypass_n), .i_dq(dq_out),
    .i_dq_oe(dq_oe), .i_strobe_pos(s_pos), .i_strobe_neg(s_neg), .o_load_n(load_n), .o_read_not_write(rnw),
    .o_addr(addr), .o_dq(dq_in), .o_mask_n(mask_n));

  ////////////////////////////////////////
  function automatic logic [BW-1:0] expect_burst(input logic [AW-1:0] a);
    logic [BW-1:0] r;
    for (int i = 0; i < 4; i++)
      r[WORD_W*i +: WORD_W] = mem[{a[AW-1:2], a[1:0] + 2'(i)}];
    return r;
  endfunction : expect_burst

  task automatic store(input logic [AW-1:0] a, input logic [BW-1:0] d, input logic [4*LANES-1:0] m);
    for (int i = 0; i < 4 * LANES; i++)
      if (!m[i])
        mem[{a[AW-1:2], a[1:0] + 2'(i / LANES)}][LANE_W*(i%LANES) +: LANE_W] =
          d[WORD_W*(i/LANES) + LANE_W*(i%LANES) +: LANE_W];
  endtask : store

  task automatic cmp(input string n, input logic [BW-1:0] e, input logic [BW-1:0] s);
    checks++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : cmp

  task automatic complete_run;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////
  always @(posedge i_core_clk)
  begin
    if (wr_done === 1'b1)
      wr_seen++;
    if (rd_done === 1'b1)
      rd_seen++;
  end

  initial
  begin
    repeat (20000) @(posedge i_core_clk);
    errors++;
    complete_run();
  end

  initial
  begin
    void'($urandom(28084));
    repeat (16) @(posedge i_core_clk);
    i_rst <= 1'b0;
    repeat (6) @(posedge kclk);
    cmp("oe idle", '0, BW'(dq_oe));
    for (int i = 0; i < 2**AW; i += 4)
    begin
      d = BW'({$urandom, $urandom, $urandom, $urandom, $urandom});
      ctrl.write_burst(AW'(i), d, '0, 1'b0);
      store(AW'(i), d, '0);
      n_wr++;
    end
    for (int i = 0; i < 40; i++)
    begin
      @(posedge i_core_clk);
      bypass_n <= (i < 2) ? i[0] : 1'($urandom);
      single <= (i < 2) ? i[0] : 1'($urandom);
      repeat (4) @(posedge kclk);
      a = AW'($urandom);
      d = BW'({$urandom, $urandom, $urandom, $urandom, $urandom});
      m = (i == 0) ? 16'hFFFF : ((i == 1) ? 16'h0000 : 16'($urandom));
      ctrl.write_burst(a, d, m, 1'($urandom));
      #1;
      cmp("oe after write", '0, BW'(dq_oe));
      store(a, d, m);
      n_wr++;
      ctrl.read_burst(a, q);
      cmp("read burst", expect_burst(a), q);
    end
    repeat (12) @(posedge i_core_clk);
    cmp("write done count", BW'(n_wr), BW'(wr_seen));
    cmp("read done count", BW'(40), BW'(rd_seen));
    complete_run();
  end
endmodule : ddr_burst_sram_test
